// ===== include/cfc_defines.svh
// Constants for the fault and mode control block
`ifndef CFC_DEFINES_SVH
`define CFC_DEFINES_SVH
`define CFC_ADDR_W        24
`define CFC_DATA_W        16
`define CFC_STAT_W        8
`define CFC_OFF_MSW       12'h000
`define CFC_OFF_CMD       12'h004
`define CFC_OFF_STATUS    12'h008
`define CFC_MSW_PE        0
`define CFC_MSW_MP        1
`define CFC_MSW_TS        3
`define CFC_CMD_CLR_TS    0
`define CFC_VEC_NO_EXT    8'h07
`define CFC_VEC_DOUBLE    8'h08
`define CFC_RST_CS        16'hf000
`define CFC_RST_IP        16'hfff0
`define CFC_UPPER_HIGH    4'hf
`define CFC_UPPER_LOW     4'h0
`define CFC_STAT_HALT     8'h03
`define CFC_STAT_IDLE     8'hff
`endif

// ===== include/cfc_pkg.sv
// Types shared by the fault and mode control block
package cfc_pkg;
	typedef enum logic [3:0] {
		CFC_RUN    = 4'b0001,
		CFC_FAULT  = 4'b0010,
		CFC_DOUBLE = 4'b0100,
		CFC_SHUT   = 4'b1000
	} cfc_fault_t;
	typedef enum logic [2:0] {
		CFC_OP_ADJ  = 3'h0,
		CFC_OP_VERIFY_READABLE_OP = 3'h1,
		CFC_OP_VERIFY_WRITABLE_OP = 3'h2,
		CFC_OP_LSL  = 3'h3,
		CFC_OP_LAR  = 3'h4
	} cfc_ptr_op_t;
	typedef enum logic [1:0] {
		CFC_SEG_CODE  = 2'h0,
		CFC_SEG_DATA  = 2'h1,
		CFC_SEG_EXTRA = 2'h2,
		CFC_SEG_STACK = 2'h3
	} cfc_seg_t;
endpackage : cfc_pkg

// ===== rtl/cfc_core.sv
// Fault escalation, mode control and pointer test logic with APB registers
//
// Behaviour
// - Every completed task switch sets task_switched_flag in machine_status_word.
// - Task switch never saves or reloads the extension's internal context.
// - Extension instruction with task switched and extension present traps on vector 7.
// - Pointer tests never raise exceptions; outcome only through zero_condition_flag.
// - Adjust op raises selector level to the maximum; flag set only on change.
// - Verify ops set flag when segment readable or writable, else clear it.
// - Limit load copies limit only when permitted; flag set on success.
// - Rights load copies rights byte only when permitted; flag set on success.
// - Two exceptions within one instruction produce double fault on vector 8.
// - Exception during double fault processing enters shutdown; nothing executes.
// - Shutdown left by nonmaskable interrupt, mode kept, or by reset.
// - Entering shutdown runs a halt bus cycle with address_bit_one low.
// - After reset execution starts in real address mode.
// - After reset real-mode code accesses drive upper_address_lines high until code segment reload.
// - After code reload real-mode code accesses drive them low; other segments low in real mode, passed through in protected mode.
// - Reset sets code segment and instruction pointer to F000:FFF0.
// - Jump to a task state segment pulses load_task_state to request a load of task, table, segment and general registers.
// - Local bus has 24 address, 16 data and 8 status lines.
`timescale 1ns/100ps
`include "cfc_defines.svh"

module cfc_core #(
	parameter int ADDR_W = `CFC_ADDR_W,
	parameter int DATA_W = `CFC_DATA_W,
	parameter int STAT_W = `CFC_STAT_W
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic [11:0]         paddr,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                task_switch_done,
	input  wire logic                tss_jump,
	input  wire logic                cop_instr_valid,
	input  wire logic                exc_valid,
	input  wire logic [7:0]          exc_vector_in,
	input  wire logic                instr_retire,
	input  wire logic                nmi_in,
	input  wire logic                cs_reload,
	input  wire logic [15:0]         cs_new,
	input  wire logic [15:0]         ip_new,
	input  wire logic                mem_access_valid,
	input  wire logic [1:0]          mem_seg,
	input  wire logic [ADDR_W-1:0]   mem_addr,
	input  wire logic                ptr_op_valid,
	input  wire logic [2:0]          ptr_op,
	input  wire logic [1:0]          sel_rpl,
	input  wire logic [1:0]          reg_rpl,
	input  wire logic                desc_valid,
	input  wire logic                priv_ok,
	input  wire logic                desc_readable,
	input  wire logic                desc_writable,
	input  wire logic                limit_type_ok,
	input  wire logic [DATA_W-1:0]   desc_limit,
	input  wire logic [7:0]          desc_rights,
	output logic                     exc_take,
	output logic [7:0]               exc_vector,
	output logic                     shutdown,
	output logic                     halt_cycle,
	output logic                     address_bit_one,
	output logic [STAT_W-1:0]        bus_status,
	output logic [ADDR_W-1:0]        phys_addr,
	output logic                     phys_addr_valid,
	output logic [15:0]              code_seg,
	output logic [15:0]              instr_ptr,
	output logic                     load_task_state,
	output logic                     protection_enable_flag,
	output logic                     zero_condition_flag,
	output logic                     ptr_done,
	output logic [DATA_W-1:0]        ptr_result,
	output logic                     ptr_result_we,
	output logic [1:0]               ptr_rpl
);

	typedef struct packed {
		logic                pe;
		logic                mp;
		logic                ts;
		cfc_pkg::cfc_fault_t fst;
		logic                cs_fresh;
		logic [15:0]         cs;
		logic [15:0]         ip;
		logic                exc_take;
		logic [7:0]          exc_vec;
		logic                shut;
		logic                halt;
		logic                a1;
		logic [STAT_W-1:0]   stat;
		logic [ADDR_W-1:0]   addr;
		logic                addr_v;
		logic                load_task;
		logic                zf;
		logic                pdone;
		logic [DATA_W-1:0]   pres;
		logic                pwe;
		logic [1:0]          prpl;
		logic                pready;
		logic [31:0]         prdata;
		logic                pslverr;
	} cfc_state_t;

	cfc_state_t s_q;
	cfc_state_t s_d;

	logic acc_phase;
	logic acc_done;
	logic mapped;
	logic cop_trap;
	logic exc_ev;
	logic clr_ts;

	// Access phase decode; a write lands only on the edge where pready is seen high
	assign acc_phase = psel & penable;
	assign acc_done  = acc_phase & s_q.pready;
	assign mapped    = (paddr == `CFC_OFF_MSW) | (paddr == `CFC_OFF_CMD) |
	                   (paddr == `CFC_OFF_STATUS);
	assign clr_ts    = acc_done & pwrite & (paddr == `CFC_OFF_CMD) & pwdata[`CFC_CMD_CLR_TS];

	// Extension trap, and shutdown masks both the extension trap and the outside exception input
	assign cop_trap = cop_instr_valid & s_q.ts & s_q.mp & ~s_q.shut;
	assign exc_ev   = (exc_valid & ~s_q.shut) | cop_trap;

	// Next state of the whole block
	always_comb begin
		s_d           = s_q;
		s_d.exc_take  = 1'b0;
		s_d.halt      = 1'b0;
		s_d.stat      = `CFC_STAT_IDLE;
		s_d.addr_v    = 1'b0;
		s_d.load_task = 1'b0;
		s_d.pdone     = 1'b0;
		s_d.pwe       = 1'b0;

		// APB slave: one wait state, then data and error stand with pready
		s_d.pready  = acc_phase & ~s_q.pready;
		s_d.pslverr = acc_phase & ~s_q.pready & ~mapped;
		s_d.prdata  = 32'h0000_0000;
		if (acc_phase & ~s_q.pready & ~pwrite) begin
			case (paddr)
				`CFC_OFF_MSW: begin
					s_d.prdata[`CFC_MSW_PE] = s_q.pe;
					s_d.prdata[`CFC_MSW_MP] = s_q.mp;
					s_d.prdata[`CFC_MSW_TS] = s_q.ts;
				end
				`CFC_OFF_STATUS: begin
					s_d.prdata[3:0]  = s_q.fst;
					s_d.prdata[4]    = s_q.cs_fresh;
					s_d.prdata[15:8] = s_q.exc_vec;
				end
				default: s_d.prdata = 32'h0000_0000;
			endcase
		end

		// Status word load: protection enable can be set but only reset clears it
		if (acc_done & pwrite & (paddr == `CFC_OFF_MSW)) begin
			s_d.pe = s_q.pe | pwdata[`CFC_MSW_PE];
			s_d.mp = pwdata[`CFC_MSW_MP];
		end

		// Task switched flag: the switch sets it and wins over a clear in the same cycle
		if (clr_ts) begin
			s_d.ts = 1'b0;
		end
		if (task_switch_done & ~s_q.shut) begin
			s_d.ts = 1'b1;
			// Only the flag moves; extension context is left for the trap handler
		end

		// Task state segment jump requests the full register reload
		s_d.load_task = tss_jump & ~s_q.shut;

		// Fault escalation
		case (s_q.fst)
			cfc_pkg::CFC_RUN: begin
				if (exc_ev) begin
					s_d.exc_take = 1'b1;
					s_d.exc_vec  = cop_trap ? `CFC_VEC_NO_EXT : exc_vector_in;
					s_d.fst      = cfc_pkg::CFC_FAULT;
				end
			end
			cfc_pkg::CFC_FAULT: begin
				if (exc_ev) begin
					s_d.exc_take = 1'b1;
					s_d.exc_vec  = `CFC_VEC_DOUBLE;
					s_d.fst      = cfc_pkg::CFC_DOUBLE;
				end else if (instr_retire) begin
					s_d.fst = cfc_pkg::CFC_RUN;
				end
			end
			cfc_pkg::CFC_DOUBLE: begin
				if (exc_ev) begin
					s_d.fst  = cfc_pkg::CFC_SHUT;
					s_d.shut = 1'b1;
					s_d.halt = 1'b1;
					s_d.a1   = 1'b0;
					s_d.stat = `CFC_STAT_HALT;
				end else if (instr_retire) begin
					s_d.fst = cfc_pkg::CFC_RUN;
				end
			end
			cfc_pkg::CFC_SHUT: begin
				// Besides reset, only the interrupt gets out; protection mode is kept as it was
				if (nmi_in) begin
					s_d.fst  = cfc_pkg::CFC_RUN;
					s_d.shut = 1'b0;
					s_d.a1   = 1'b1;
				end
			end
			default: s_d.fst = cfc_pkg::CFC_RUN;
		endcase

		// Code segment reload ends the top-of-memory window until the next reset
		if (cs_reload & ~s_q.shut) begin
			s_d.cs       = cs_new;
			s_d.ip       = ip_new;
			s_d.cs_fresh = 1'b0;
		end

		// Real mode forces the upper lines; protected accesses arrive translated
		if (mem_access_valid & ~s_q.shut) begin
			s_d.addr_v = 1'b1;
			s_d.addr   = mem_addr;
			if (!s_q.pe) begin
				if ((mem_seg == cfc_pkg::CFC_SEG_CODE) && s_q.cs_fresh) begin
					s_d.addr[ADDR_W-1 -: 4] = `CFC_UPPER_HIGH;
				end else begin
					s_d.addr[ADDR_W-1 -: 4] = `CFC_UPPER_LOW;
				end
			end
		end

		// Pointer tests report only through the flag, never through exc_take
		if (ptr_op_valid & ~s_q.shut) begin
			s_d.pdone = 1'b1;
			case (ptr_op)
				cfc_pkg::CFC_OP_ADJ: begin
					s_d.zf   = reg_rpl > sel_rpl;
					s_d.prpl = (reg_rpl > sel_rpl) ? reg_rpl : sel_rpl;
				end
				cfc_pkg::CFC_OP_VERIFY_READABLE_OP: s_d.zf = desc_valid & priv_ok & desc_readable;
				cfc_pkg::CFC_OP_VERIFY_WRITABLE_OP: s_d.zf = desc_valid & priv_ok & desc_writable;
				cfc_pkg::CFC_OP_LSL: begin
					s_d.zf = desc_valid & priv_ok & limit_type_ok;
					if (desc_valid & priv_ok & limit_type_ok) begin
						s_d.pres = desc_limit;
						s_d.pwe  = 1'b1;
					end
				end
				cfc_pkg::CFC_OP_LAR: begin
					s_d.zf = desc_valid & priv_ok;
					if (desc_valid & priv_ok) begin
						s_d.pres = {{(DATA_W-8){1'b0}}, desc_rights};
						s_d.pwe  = 1'b1;
					end
				end
				default: s_d.pdone = 1'b0;
			endcase
		end
	end

	// State register; reset returns to real mode at the reset vector
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q          <= '0;
			s_q.fst      <= cfc_pkg::CFC_RUN;
			s_q.pe       <= 1'b0;
			s_q.cs_fresh <= 1'b1;
			s_q.cs       <= `CFC_RST_CS;
			s_q.ip       <= `CFC_RST_IP;
			s_q.a1       <= 1'b1;
			s_q.stat     <= `CFC_STAT_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	assign prdata                 = s_q.prdata;
	assign pready                 = s_q.pready;
	assign pslverr                = s_q.pslverr;
	assign exc_take               = s_q.exc_take;
	assign exc_vector             = s_q.exc_vec;
	assign shutdown               = s_q.shut;
	assign halt_cycle             = s_q.halt;
	assign address_bit_one        = s_q.a1;
	assign bus_status             = s_q.stat;
	assign phys_addr              = s_q.addr;
	assign phys_addr_valid        = s_q.addr_v;
	assign code_seg               = s_q.cs;
	assign instr_ptr              = s_q.ip;
	assign load_task_state        = s_q.load_task;
	assign protection_enable_flag = s_q.pe;
	assign zero_condition_flag    = s_q.zf;
	assign ptr_done               = s_q.pdone;
	assign ptr_result             = s_q.pres;
	assign ptr_result_we          = s_q.pwe;
	assign ptr_rpl                = s_q.prpl;

	// Checks on the design's own behaviour
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_ts_set;
		task_switch_done && !s_q.shut |=> s_q.ts;
	endproperty
	a_ts_set: assert property (p_ts_set) else $error("task switch did not set flag");

	property p_cop_trap;
		s_q.fst == cfc_pkg::CFC_RUN && cop_instr_valid && s_q.ts && s_q.mp && !s_q.shut
			|=> exc_take && exc_vector == 8'h07;
	endproperty
	a_cop_trap: assert property (p_cop_trap) else $error("missing vector 7 trap");

	property p_no_trap_clear;
		s_q.ts && !clr_ts |=> s_q.ts;
	endproperty
	a_no_trap_clear: assert property (p_no_trap_clear) else $error("flag lost");

	property p_ptr_no_exc;
		ptr_op_valid && !exc_valid && !cop_instr_valid |=> !exc_take;
	endproperty
	a_ptr_no_exc: assert property (p_ptr_no_exc) else $error("pointer test raised fault");

	property p_adj;
		ptr_op_valid && !s_q.shut && ptr_op == 3'h0
			|=> zero_condition_flag == ($past(reg_rpl) > $past(sel_rpl))
			&& ptr_rpl >= $past(sel_rpl) && ptr_rpl >= $past(reg_rpl);
	endproperty
	a_adj: assert property (p_adj) else $error("adjust result wrong");

	property p_lsl_we;
		ptr_result_we |-> zero_condition_flag && ptr_done;
	endproperty
	a_lsl_we: assert property (p_lsl_we) else $error("result written without success");

	property p_double;
		s_q.fst == cfc_pkg::CFC_FAULT && exc_valid |=> exc_take && exc_vector == 8'h08;
	endproperty
	a_double: assert property (p_double) else $error("double fault not taken");

	property p_shut_enter;
		s_q.fst == cfc_pkg::CFC_DOUBLE && exc_valid
			|=> shutdown && halt_cycle && !address_bit_one && !exc_take;
	endproperty
	a_shut_enter: assert property (p_shut_enter) else $error("shutdown entry wrong");

	property p_shut_hold;
		shutdown && !nmi_in |=> shutdown && !exc_take && !ptr_done;
	endproperty
	a_shut_hold: assert property (p_shut_hold) else $error("activity in shutdown");

	property p_nmi_exit;
		shutdown && nmi_in |=> !shutdown && $stable(protection_enable_flag);
	endproperty
	a_nmi_exit: assert property (p_nmi_exit) else $error("interrupt exit wrong");

	property p_upper_high;
		mem_access_valid && !s_q.pe && !s_q.shut && s_q.cs_fresh && mem_seg == 2'h0
			|=> phys_addr_valid && phys_addr[ADDR_W-1 -: 4] == 4'hf;
	endproperty
	a_upper_high: assert property (p_upper_high) else $error("upper lines not high");

	property p_upper_low;
		mem_access_valid && !s_q.pe && !s_q.shut && mem_seg != 2'h0
			|=> phys_addr[ADDR_W-1 -: 4] == 4'h0;
	endproperty
	a_upper_low: assert property (p_upper_low) else $error("upper lines not low");

	property p_apb_wait;
		psel && penable && !pready |=> pready;
	endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("apb answer late");

	c_shutdown: cover property (s_q.fst == cfc_pkg::CFC_DOUBLE && exc_valid);
	c_cop_trap: cover property (cop_trap);
	c_nmi_exit: cover property (shutdown && nmi_in);
	c_lar_ok:   cover property (ptr_op_valid && ptr_op == 3'h4 && desc_valid && priv_ok);

endmodule : cfc_core

// ===== tb/cfc_desc_model.sv
// Descriptor table stand-in that answers the block's pointer test lookups
`timescale 1ns/100ps

module cfc_desc_model (
	input  wire logic [1:0]  idx,
	output logic             desc_valid,
	output logic             priv_ok,
	output logic             desc_readable,
	output logic             desc_writable,
	output logic             limit_type_ok,
	output logic [15:0]      desc_limit,
	output logic [7:0]       desc_rights
);
	// Entry 0 grants every access and entry 1 fails privilege; entry 2 is readable but not
	// writable and has a bad limit type; entry 3 is not valid. A test that mixes up the
	// qualifiers cannot pass.
	// Each lookup is answered combinationally from idx
	always_comb begin
		desc_valid    = (idx != 2'h3);
		priv_ok       = (idx != 2'h1);
		desc_readable = (idx != 2'h1);
		desc_writable = (idx == 2'h0);
		limit_type_ok = (idx != 2'h2);
		desc_limit    = (idx == 2'h0) ? 16'h1234 : 16'habcd;
		desc_rights   = (idx == 2'h0) ? 8'h93 : 8'h81;
	end
endmodule : cfc_desc_model

// ===== tb/test_cpu_fault_and_mode_control.sv
// Self-checking bench for the fault and mode control block
`timescale 1ns/100ps
`include "cfc_defines.svh"

module test_cpu_fault_and_mode_control;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        task_switch_done, tss_jump, cop_instr_valid, exc_valid, instr_retire;
	logic        nmi_in, cs_reload, mem_access_valid, ptr_op_valid;
	logic [7:0]  exc_vector_in, exc_vector, bus_status, desc_rights;
	logic [15:0] cs_new, ip_new, code_seg, instr_ptr, desc_limit, ptr_result;
	logic [1:0]  mem_seg, sel_rpl, reg_rpl, idx, ptr_rpl;
	logic [23:0] mem_addr, phys_addr;
	logic [2:0]  ptr_op;
	logic        desc_valid, priv_ok, desc_readable, desc_writable, limit_type_ok;
	logic        exc_take, shutdown, halt_cycle, address_bit_one, phys_addr_valid;
	logic        load_task_state, protection_enable_flag, zero_condition_flag;
	logic        ptr_done, ptr_result_we;
	int          error_cnt;
	int          n_compared;

	cfc_core i_cfc_core (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .task_switch_done, .tss_jump, .cop_instr_valid, .exc_valid,
		.exc_vector_in, .instr_retire, .nmi_in, .cs_reload, .cs_new, .ip_new,
		.mem_access_valid, .mem_seg, .mem_addr, .ptr_op_valid, .ptr_op, .sel_rpl, .reg_rpl,
		.desc_valid, .priv_ok, .desc_readable, .desc_writable, .limit_type_ok, .desc_limit,
		.desc_rights, .exc_take, .exc_vector, .shutdown, .halt_cycle, .address_bit_one,
		.bus_status, .phys_addr, .phys_addr_valid, .code_seg, .instr_ptr, .load_task_state,
		.protection_enable_flag, .zero_condition_flag, .ptr_done, .ptr_result,
		.ptr_result_we, .ptr_rpl);

	cfc_desc_model i_cfc_desc_model (.idx, .desc_valid, .priv_ok, .desc_readable,
		.desc_writable, .limit_type_ok, .desc_limit, .desc_rights);

	// Free-running 20 MHz clock
	always #25 pclk = ~pclk;

	task automatic finish_test;
		if (error_cnt == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic do_reset;
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		#1;
	endtask : do_reset

	// Drops every event strobe one edge after it was raised, then lets outputs settle
	task automatic settle;
		@(posedge pclk);
		{task_switch_done, tss_jump, cop_instr_valid, exc_valid} <= 4'h0;
		{instr_retire, nmi_in, cs_reload, mem_access_valid, ptr_op_valid} <= 5'h0;
		#1;
	endtask : settle

	// One APB transfer; the wait for pready is bounded so a dead slave ends the run
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 16) begin
			error_cnt++;
			finish_test();
		end
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, a, d, rd, err);
	endtask : wr

	task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
			input string what);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 32'h0, rd, err);
		chk(what, rd & m, e);
	endtask : rdchk

	task automatic exc(input logic [7:0] v);
		@(posedge pclk);
		exc_valid <= 1'b1;
		exc_vector_in <= v;
		settle;
	endtask : exc

	task automatic mem(input logic [1:0] sg, input logic [23:0] a, input logic [23:0] e);
		@(posedge pclk);
		mem_access_valid <= 1'b1;
		mem_seg <= sg;
		mem_addr <= a;
		settle;
		chk("phys_addr", 32'({phys_addr_valid, phys_addr}), 32'({1'b1, e}));
	endtask : mem

	task automatic t_reset_state;
		logic [31:0] rd;
		logic        err;
		chk("reset_cs_ip", {code_seg, instr_ptr}, 32'hf000fff0);
		chk("reset_pe", 32'(protection_enable_flag), 32'h0);
		chk("idle_bus", 32'({address_bit_one, bus_status}), 32'h1ff);
		chk("bus_widths", {8'($bits(phys_addr)), 8'($bits(ptr_result)), 16'($bits(bus_status))},
			32'h18100008);
		rdchk(`CFC_OFF_STATUS, 32'h1f, 32'h11, "status_reset");
		apb(1'b0, 12'h00c, 32'h0, rd, err);
		chk("unmapped_err", 32'(err), 32'h1);
	endtask : t_reset_state

	// Upper lines are forced high only for code fetches until the code segment is reloaded
	task automatic t_upper;
		mem(cfc_pkg::CFC_SEG_CODE, 24'h01fff0, 24'hf1fff0);
		mem(cfc_pkg::CFC_SEG_DATA, 24'h312345, 24'h012345);
		mem(cfc_pkg::CFC_SEG_EXTRA, 24'h5a0001, 24'h0a0001);
		mem(cfc_pkg::CFC_SEG_STACK, 24'hf0ffff, 24'h00ffff);
		@(posedge pclk);
		cs_reload <= 1'b1;
		cs_new <= 16'h1000;
		ip_new <= 16'h0100;
		settle;
		chk("reload_cs_ip", {code_seg, instr_ptr}, 32'h10000100);
		rdchk(`CFC_OFF_STATUS, 32'h10, 32'h0, "status_reload");
		mem(cfc_pkg::CFC_SEG_CODE, 24'h3abcde, 24'h0abcde);
	endtask : t_upper

	task automatic t_tsw;
		@(posedge pclk);
		task_switch_done <= 1'b1;
		settle;
		@(posedge pclk);
		cop_instr_valid <= 1'b1;
		settle;
		chk("no_trap_mp0", 32'(exc_take), 32'h0);
		wr(`CFC_OFF_CMD, 32'h1);
		wr(`CFC_OFF_MSW, 32'h2);
		rdchk(`CFC_OFF_MSW, 32'hb, 32'h2, "msw_cleared");
		@(posedge pclk);
		task_switch_done <= 1'b1;
		settle;
		rdchk(`CFC_OFF_MSW, 32'hb, 32'ha, "msw_ts_set");
		@(posedge pclk);
		cop_instr_valid <= 1'b1;
		settle;
		chk("trap_7", 32'({exc_take, exc_vector}), 32'h107);
		@(posedge pclk);
		instr_retire <= 1'b1;
		settle;
		rdchk(`CFC_OFF_MSW, 32'hb, 32'ha, "ts_sticky");
		wr(`CFC_OFF_CMD, 32'h1);
		rdchk(`CFC_OFF_MSW, 32'hb, 32'h2, "ts_cleared");
		@(posedge pclk);
		cop_instr_valid <= 1'b1;
		settle;
		chk("no_trap_ts0", 32'(exc_take), 32'h0);
		@(posedge pclk);
		tss_jump <= 1'b1;
		settle;
		chk("task_load", 32'(load_task_state), 32'h1);
	endtask : t_tsw

	task automatic ptr_case(input logic [2:0] op, input logic [1:0] ix, s, r,
			input logic ezf, input logic ewe, input logic [15:0] eres);
		@(posedge pclk);
		ptr_op_valid <= 1'b1;
		ptr_op <= op;
		idx <= ix;
		sel_rpl <= s;
		reg_rpl <= r;
		settle;
		chk("ptr_done_no_exc", 32'({ptr_done, exc_take}), 32'h2);
		chk("zero_flag", 32'(zero_condition_flag), 32'(ezf));
		if (op >= 3'h3) begin
			chk("ptr_we", 32'(ptr_result_we), 32'(ewe));
		end
		if (ewe) begin
			chk("ptr_res", 32'(ptr_result), 32'(eres));
		end
	endtask : ptr_case

	// Flag values alternate so a flag that never updates is caught
	task automatic t_ptr;
		ptr_case(cfc_pkg::CFC_OP_ADJ, 2'h0, 2'h1, 2'h3, 1'b1, 1'b0, 16'h0);
		chk("rpl_raised", 32'(ptr_rpl), 32'h3);
		ptr_case(cfc_pkg::CFC_OP_ADJ, 2'h0, 2'h2, 2'h1, 1'b0, 1'b0, 16'h0);
		chk("rpl_kept", 32'(ptr_rpl), 32'h2);
		ptr_case(cfc_pkg::CFC_OP_VERIFY_READABLE_OP, 2'h0, 2'h0, 2'h0, 1'b1, 1'b0, 16'h0);
		ptr_case(cfc_pkg::CFC_OP_VERIFY_READABLE_OP, 2'h1, 2'h0, 2'h0, 1'b0, 1'b0, 16'h0);
		ptr_case(cfc_pkg::CFC_OP_VERIFY_WRITABLE_OP, 2'h0, 2'h0, 2'h0, 1'b1, 1'b0, 16'h0);
		ptr_case(cfc_pkg::CFC_OP_VERIFY_WRITABLE_OP, 2'h1, 2'h0, 2'h0, 1'b0, 1'b0, 16'h0);
		ptr_case(cfc_pkg::CFC_OP_LSL, 2'h0, 2'h0, 2'h0, 1'b1, 1'b1, 16'h1234);
		ptr_case(cfc_pkg::CFC_OP_LSL, 2'h1, 2'h0, 2'h0, 1'b0, 1'b0, 16'h0);
		ptr_case(cfc_pkg::CFC_OP_LAR, 2'h0, 2'h0, 2'h0, 1'b1, 1'b1, 16'h0093);
		ptr_case(cfc_pkg::CFC_OP_LAR, 2'h1, 2'h0, 2'h0, 1'b0, 1'b0, 16'h0);
		// Read-only entry tells the two verify ops apart; bad type fails only the limit load
		ptr_case(cfc_pkg::CFC_OP_VERIFY_READABLE_OP, 2'h2, 2'h0, 2'h0, 1'b1, 1'b0, 16'h0);
		ptr_case(cfc_pkg::CFC_OP_VERIFY_WRITABLE_OP, 2'h2, 2'h0, 2'h0, 1'b0, 1'b0, 16'h0);
		ptr_case(cfc_pkg::CFC_OP_LAR, 2'h2, 2'h0, 2'h0, 1'b1, 1'b1, 16'h0081);
		ptr_case(cfc_pkg::CFC_OP_LSL, 2'h2, 2'h0, 2'h0, 1'b0, 1'b0, 16'h0);
		ptr_case(cfc_pkg::CFC_OP_VERIFY_WRITABLE_OP, 2'h0, 2'h0, 2'h0, 1'b1, 1'b0, 16'h0);
		ptr_case(cfc_pkg::CFC_OP_VERIFY_READABLE_OP, 2'h3, 2'h0, 2'h0, 1'b0, 1'b0, 16'h0);
		ptr_case(cfc_pkg::CFC_OP_LSL, 2'h0, 2'h0, 2'h0, 1'b1, 1'b1, 16'h1234);
		ptr_case(cfc_pkg::CFC_OP_LAR, 2'h3, 2'h0, 2'h0, 1'b0, 1'b0, 16'h0);
		// A raise first sets the flag; equal levels then leave the selector unchanged, so the flag must clear
		ptr_case(cfc_pkg::CFC_OP_ADJ, 2'h0, 2'h1, 2'h3, 1'b1, 1'b0, 16'h0);
		ptr_case(cfc_pkg::CFC_OP_ADJ, 2'h0, 2'h2, 2'h2, 1'b0, 1'b0, 16'h0);
		chk("rpl_equal", 32'(ptr_rpl), 32'h2);
	endtask : t_ptr

	task automatic t_fault;
		wr(`CFC_OFF_MSW, 32'h1);
		// Near jump right after enabling protection flushes the real-mode queue
		@(posedge pclk);
		cs_reload <= 1'b1;
		cs_new <= code_seg;
		ip_new <= 16'h0200;
		settle;
		exc(8'h0d);
		chk("first_exc", 32'({exc_take, exc_vector}), 32'h10d);
		exc(8'h0c);
		chk("double_fault", 32'({exc_take, exc_vector}), 32'h108);
		exc(8'h0d);
		chk("shut_entry", 32'({shutdown, halt_cycle, address_bit_one, exc_take}), 32'hc);
		chk("halt_status", 32'(bus_status), 32'h03);
		exc(8'h0d);
		chk("shut_hold", 32'({shutdown, halt_cycle, exc_take, bus_status}), 32'h4ff);
		chk("a1_low", 32'(address_bit_one), 32'h0);
		@(posedge pclk);
		nmi_in <= 1'b1;
		settle;
		chk("nmi_exit", 32'({shutdown, protection_enable_flag, address_bit_one}), 32'h3);
		do_reset;
		chk("reset_exit", 32'({protection_enable_flag, code_seg}), 32'hf000);
		mem(cfc_pkg::CFC_SEG_CODE, 24'h0abcde, 24'hfabcde);
	endtask : t_fault

	initial begin
		pclk = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{task_switch_done, tss_jump, cop_instr_valid, exc_valid, instr_retire} = '0;
		{nmi_in, cs_reload, mem_access_valid, ptr_op_valid, exc_vector_in} = '0;
		{cs_new, ip_new, mem_seg, mem_addr, ptr_op, sel_rpl, reg_rpl, idx} = '0;
		error_cnt = 0;
		n_compared = 0;
		do_reset;
		t_reset_state;
		t_upper;
		t_tsw;
		t_ptr;
		t_fault;
		finish_test;
	end
endmodule : test_cpu_fault_and_mode_control
